/* File: rtl/power_boot_pkg.sv */
// power, reset and boot-source control constants
// assumes a single 40 MHz system clock
package power_boot_pkg;
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned DEBOUNCE_NS   = 1000000;
   // least time rounds up to whole cycles
   localparam int unsigned DEBOUNCE_CYC  = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W         = 16;
   localparam logic [CNT_W-1:0] DEBOUNCE_DEF = CNT_W'(DEBOUNCE_CYC);

   // debounced input index
   localparam int unsigned N_DEB   = 8;
   localparam int unsigned IX_BTN  = 0;
   localparam int unsigned IX_SLP  = 1;
   localparam int unsigned IX_LID  = 2;
   localparam int unsigned IX_BAT  = 3;
   localparam int unsigned IX_CHG  = 4;
   localparam int unsigned IX_PRS  = 5;
   localparam int unsigned IX_TST  = 6;
   localparam int unsigned IX_ALR  = 7;

   // boot-select codes, strap 2 most significant, ground reads 0
   localparam logic [2:0] BOOT_CARRIER_SATA = 3'h0;
   localparam logic [2:0] BOOT_CARRIER_SD   = 3'h1;
   localparam logic [2:0] BOOT_CARRIER_ESPI = 3'h2;
   localparam logic [2:0] BOOT_CARRIER_SPI  = 3'h3;
   localparam logic [2:0] BOOT_MODULE_NAND  = 3'h4;
   localparam logic [2:0] BOOT_REMOTE       = 3'h5;
   localparam logic [2:0] BOOT_MODULE_EMMC  = 3'h6;
   localparam logic [2:0] BOOT_MODULE_SPI   = 3'h7;

   localparam int unsigned N_STRAP = 4;
   localparam logic [N_STRAP-1:0] STRAP_RST = 4'h0;

   typedef enum logic [1:0] {
      ST_OFF,
      ST_ON,
      ST_STANDBY
   } pwr_state_e;
endpackage

/* File: rtl/input_debounce.sv */
// two-flop synchroniser followed by a stability counter for one input
// assumes the input is asynchronous and idles high (pulled up)
`timescale 1ns/1ps
module input_debounce (
   input  wire logic                            sys_clk_i,
   input  wire logic                            sys_rst_i,
   input  wire logic                            raw_i,
   input  wire logic [power_boot_pkg::CNT_W-1:0] stable_cycles_i,
   output logic                                 level_o
);
   import power_boot_pkg::*;

   typedef struct packed {
      logic             meta;
      logic             sync;
      logic             level;
      logic [CNT_W-1:0] cnt;
   } deb_s;

   deb_s st_r;
   deb_s st_nxt;

   always_comb begin
      st_nxt      = st_r;
      st_nxt.meta = raw_i;
      st_nxt.sync = st_r.meta;
      if (st_r.sync == st_r.level) begin
         st_nxt.cnt = '0;
      end else if (st_r.cnt + CNT_W'(1) >= stable_cycles_i) begin
         // a zero setting still costs one cycle so the counter never wraps
         st_nxt.level = st_r.sync;
         st_nxt.cnt   = '0;
      end else begin
         st_nxt.cnt = st_r.cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         st_r <= '{meta: 1'b1, sync: 1'b1, level: 1'b1, cnt: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign level_o = st_r.level;

   deb_hold_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (st_r.sync == st_r.level) |=> $stable(st_r.level))
      else $error("debounced level moved without change");
endmodule // input_debounce

/* File: rtl/module_power_boot_control.sv */
// power sequencing, reset and boot-source selection at the module edge
// assumes carrier inputs are open-drain, pulled up, asynchronous to sys_clk_i
`timescale 1ns/1ps
module module_power_boot_control (
   input  wire logic                             sys_clk_i,
   input  wire logic                             sys_rst_i,
   input  wire logic [power_boot_pkg::CNT_W-1:0] debounce_cycles_i,
   input  wire logic                             input_power_bad_n_i,
   input  wire logic                             reset_request_n_i,
   input  wire logic                             power_button_n_i,
   input  wire logic                             sleep_request_n_i,
   input  wire logic                             lid_closed_n_i,
   input  wire logic                             battery_low_n_i,
   input  wire logic                             charging_n_i,
   input  wire logic                             charger_present_n_i,
   input  wire logic                             test_mode_n_i,
   input  wire logic                             mgmt_bus_alert_n_i,
   input  wire logic                             boot_select_0_n_i,
   input  wire logic                             boot_select_1_n_i,
   input  wire logic                             boot_select_2_n_i,
   input  wire logic                             flash_serial_out_strap_i,
   input  wire logic                             audio_serial_out_strap_i,
   input  wire logic                             audio_bit_clock_strap_i,
   input  wire logic                             audio_frame_clock_strap_i,
   input  wire logic                             suspend_ram_state_n_i,
   input  wire logic                             system_reset_i,
   output logic                                  module_power_enable_o,
   output logic                                  carrier_power_enable_o,
   output logic                                  carrier_standby_n_o,
   output logic                                  carrier_reset_n_o,
   output logic                                  module_reset_o,
   output logic                                  power_button_o,
   output logic                                  sleep_request_o,
   output logic                                  lid_closed_o,
   output logic                                  battery_low_o,
   output logic                                  charging_o,
   output logic                                  charger_present_o,
   output logic                                  test_mode_o,
   output logic                                  mgmt_bus_irq_o,
   output logic [2:0]                            boot_select_o,
   output logic [2:0]                            boot_source_o,
   output logic [power_boot_pkg::N_STRAP-1:0]    config_strap_o,
   output logic                                  strap_pins_input_o
);
   import power_boot_pkg::*;

   logic [N_DEB-1:0] raw;
   logic [N_DEB-1:0] deb;

   assign raw[IX_BTN] = power_button_n_i;
   assign raw[IX_SLP] = sleep_request_n_i;
   assign raw[IX_LID] = lid_closed_n_i;
   assign raw[IX_BAT] = battery_low_n_i;
   assign raw[IX_CHG] = charging_n_i;
   assign raw[IX_PRS] = charger_present_n_i;
   assign raw[IX_TST] = test_mode_n_i;
   assign raw[IX_ALR] = mgmt_bus_alert_n_i;

   // every carrier status line goes through the same filter
   genvar gi;
   generate
      for (gi = 0; gi < N_DEB; gi++) begin : g_deb
         input_debounce u_deb (
            .sys_clk_i       (sys_clk_i),
            .sys_rst_i       (sys_rst_i),
            .raw_i           (raw[gi]),
            .stable_cycles_i (debounce_cycles_i),
            .level_o         (deb[gi])
         );
      end
   endgenerate

   typedef struct packed {
      logic [1:0]         pbad_sync;
      logic [1:0]         rreq_sync;
      pwr_state_e         state;
      logic               mod_en;
      logic               car_en;
      logic               stby_n;
      logic               rst_out_n;
      logic               mod_rst;
      logic [N_DEB-1:0]   status;
      logic [2:0]         boot_sel;
      logic [2:0]         boot_src;
      logic [N_STRAP-1:0] strap;
      logic               strap_in;
      logic [2:0]         bsel_s1;
      logic [2:0]         bsel_s2;
   } ctl_s;

   ctl_s st_r;
   ctl_s st_nxt;

   logic pbad_low;
   logic rreq_low;
   logic [2:0] bsel;

   always_comb begin
      st_nxt = st_r;
      pbad_low = ~st_r.pbad_sync[1];
      rreq_low = ~st_r.rreq_sync[1];
      bsel = st_r.bsel_s2;
      st_nxt.pbad_sync = {st_r.pbad_sync[0], input_power_bad_n_i};
      st_nxt.rreq_sync = {st_r.rreq_sync[0], reset_request_n_i};
      st_nxt.bsel_s1   = {boot_select_2_n_i, boot_select_1_n_i, boot_select_0_n_i};
      st_nxt.bsel_s2   = st_r.bsel_s1;
      // status outputs are active high copies of the debounced lines
      st_nxt.status = ~deb;

      case (st_r.state)
         ST_OFF: begin
            if (!pbad_low) begin
               st_nxt.state = ST_ON;
            end
         end
         ST_ON: begin
            if (pbad_low) begin
               st_nxt.state = ST_OFF;
            end else if (!suspend_ram_state_n_i) begin
               st_nxt.state = ST_STANDBY;
            end
         end
         ST_STANDBY: begin
            if (pbad_low) begin
               st_nxt.state = ST_OFF;
            end else if (suspend_ram_state_n_i) begin
               st_nxt.state = ST_ON;
            end
         end
         default: begin
            st_nxt.state = ST_OFF;
         end
      endcase

      st_nxt.mod_en = (st_nxt.state != ST_OFF);
      st_nxt.car_en = (st_nxt.state == ST_ON);
      st_nxt.stby_n = (st_nxt.state == ST_ON);
      st_nxt.mod_rst   = rreq_low | system_reset_i | (st_nxt.state == ST_OFF);
      st_nxt.rst_out_n = ~st_nxt.mod_rst;
      st_nxt.strap_in  = st_nxt.mod_rst;

      // straps are captured throughout reset; last value before release holds
      if (st_r.mod_rst) begin
         st_nxt.strap = {audio_frame_clock_strap_i, audio_bit_clock_strap_i,
                         audio_serial_out_strap_i, flash_serial_out_strap_i};
         st_nxt.boot_sel = bsel;
         st_nxt.boot_src = (bsel == BOOT_CARRIER_SPI) ? BOOT_CARRIER_SPI : BOOT_MODULE_SPI;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         st_r <= '{pbad_sync: 2'h0, rreq_sync: 2'h3, state: ST_OFF, mod_en: 1'b0,
                   car_en: 1'b0, stby_n: 1'b0, rst_out_n: 1'b0, mod_rst: 1'b1, status: '0,
                   boot_sel: BOOT_MODULE_SPI, boot_src: BOOT_MODULE_SPI, strap: STRAP_RST,
                   strap_in: 1'b1, bsel_s1: 3'h7, bsel_s2: 3'h7};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign module_power_enable_o  = st_r.mod_en;
   assign carrier_power_enable_o = st_r.car_en;
   assign carrier_standby_n_o    = st_r.stby_n;
   assign carrier_reset_n_o      = st_r.rst_out_n;
   assign module_reset_o         = st_r.mod_rst;
   assign power_button_o         = st_r.status[IX_BTN];
   assign sleep_request_o        = st_r.status[IX_SLP];
   assign lid_closed_o           = st_r.status[IX_LID];
   assign battery_low_o          = st_r.status[IX_BAT];
   assign charging_o             = st_r.status[IX_CHG];
   assign charger_present_o      = st_r.status[IX_PRS];
   assign test_mode_o            = st_r.status[IX_TST];
   assign mgmt_bus_irq_o         = st_r.status[IX_ALR];
   assign boot_select_o          = st_r.boot_sel;
   assign boot_source_o          = st_r.boot_src;
   assign config_strap_o         = st_r.strap;
   assign strap_pins_input_o     = st_r.strap_in;

   power_bad_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      !st_r.pbad_sync[1] |=> !module_power_enable_o && !carrier_power_enable_o)
      else $error("power enabled while power bad");
   // pin to enables is two sync flops and the state register
   pin_bad_off_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      !input_power_bad_n_i |-> ##3 (!module_power_enable_o && !carrier_power_enable_o))
      else $error("power enabled after power-bad pin low");
   carrier_on_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      carrier_power_enable_o |-> module_power_enable_o)
      else $error("carrier on without module power");
   standby_low_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (st_r.state == ST_STANDBY) |-> !carrier_standby_n_o)
      else $error("standby output high in standby");
   reset_out_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      carrier_reset_n_o == !module_reset_o)
      else $error("reset output disagrees with module reset");
   reset_req_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      !st_r.rreq_sync[1] |=> module_reset_o)
      else $error("reset request ignored");
   boot_src_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      boot_source_o == BOOT_CARRIER_SPI || boot_source_o == BOOT_MODULE_SPI)
      else $error("bad boot source");
   boot_map_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (boot_select_o == BOOT_CARRIER_SPI) == (boot_source_o == BOOT_CARRIER_SPI))
      else $error("boot map wrong");
   strap_hold_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      !module_reset_o && !$past(module_reset_o) |-> $stable(config_strap_o))
      else $error("strap changed out of reset");
   irq_follow_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      ##1 mgmt_bus_irq_o == !$past(deb[IX_ALR]))
      else $error("alert not forwarded");
   // a rising alert output needs the pin low four edges back: meta, sync, level, output
   alert_pin_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $rose(mgmt_bus_irq_o) |-> !$past(mgmt_bus_alert_n_i, 4))
      else $error("alert raised without low alert pin");

   cov_power_up_c: cover property (@(posedge sys_clk_i) $rose(carrier_power_enable_o));
   cov_standby_c: cover property (@(posedge sys_clk_i) $fell(carrier_standby_n_o) && module_power_enable_o);
   cov_carrier_spi_c: cover property (@(posedge sys_clk_i) boot_source_o == BOOT_CARRIER_SPI);
   cov_button_c: cover property (@(posedge sys_clk_i) $rose(power_button_o));
endmodule // module_power_boot_control

/* File: verif/carrier_model.sv */
// carrier-side model: open-drain pulls onto module pins
// assumes a module pull-up on every pin, so a released line reads 1
`timescale 1ns/1ps
module carrier_model (
   input  wire logic [7:0] status_pull_i,
   input  wire logic       power_bad_pull_i,
   input  wire logic       reset_pull_i,
   input  wire logic [2:0] boot_ground_i,
   output logic [7:0]      status_pin_o,
   output logic            power_bad_pin_o,
   output logic            reset_pin_o,
   output logic [2:0]      boot_pin_o
);
   // released lines go to the pull-up level, never the last driven value
   assign status_pin_o    = ~status_pull_i;
   assign power_bad_pin_o = ~power_bad_pull_i;
   assign reset_pin_o     = ~reset_pull_i;
   assign boot_pin_o      = ~boot_ground_i;
   // strap pins are left unconnected here; the testbench drives them directly
endmodule // carrier_model

/* File: verif/module_power_boot_control_tb_top.sv */
// scoreboard testbench for the power, reset and boot control block
// assumes a 40 MHz clock and a stability count of 4 cycles, raised to 8 late in the run
`timescale 1ns/1ps
module module_power_boot_control_tb_top;
   import power_boot_pkg::*;
   typedef struct packed {logic [2:0] k; logic [7:0] v;} note_s;
   logic       sys_clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic       susp_n  = 1'b1;
   logic       sys_req = 1'b0;
   logic [7:0] st_pull = 8'h00;
   logic       pb_pull = 1'b1;
   logic       rr_pull = 1'b0;
   logic [2:0] bt_gnd  = 3'h0;
   logic [3:0] strap   = 4'h0;
   logic [15:0] deb_cyc = 16'h0004;
   logic [7:0] st_pin, st_out;
   logic       pb_pin, rr_pin, mpe, cpe, stby_n, crst_n, mrst, spin;
   logic [2:0] bt_pin, bsel, bsrc;
   logic [3:0] cfg;
   note_s      q[$];
   int         n_fail = 0;
   int         checks_done = 0;
   event       take;

   always #12.5 sys_clk = ~sys_clk;

   carrier_model carrier_model_inst (.status_pull_i(st_pull), .power_bad_pull_i(pb_pull), .reset_pull_i(rr_pull),
      .boot_ground_i(bt_gnd), .status_pin_o(st_pin), .power_bad_pin_o(pb_pin), .reset_pin_o(rr_pin),
      .boot_pin_o(bt_pin));

   module_power_boot_control module_power_boot_control_inst (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst),
      .debounce_cycles_i(deb_cyc), .input_power_bad_n_i(pb_pin), .reset_request_n_i(rr_pin),
      .power_button_n_i(st_pin[IX_BTN]), .sleep_request_n_i(st_pin[IX_SLP]), .lid_closed_n_i(st_pin[IX_LID]),
      .battery_low_n_i(st_pin[IX_BAT]), .charging_n_i(st_pin[IX_CHG]), .charger_present_n_i(st_pin[IX_PRS]),
      .test_mode_n_i(st_pin[IX_TST]), .mgmt_bus_alert_n_i(st_pin[IX_ALR]), .boot_select_0_n_i(bt_pin[0]),
      .boot_select_1_n_i(bt_pin[1]), .boot_select_2_n_i(bt_pin[2]), .flash_serial_out_strap_i(strap[0]),
      .audio_serial_out_strap_i(strap[1]), .audio_bit_clock_strap_i(strap[2]),
      .audio_frame_clock_strap_i(strap[3]), .suspend_ram_state_n_i(susp_n), .system_reset_i(sys_req),
      .module_power_enable_o(mpe), .carrier_power_enable_o(cpe), .carrier_standby_n_o(stby_n),
      .carrier_reset_n_o(crst_n), .module_reset_o(mrst), .power_button_o(st_out[IX_BTN]),
      .sleep_request_o(st_out[IX_SLP]), .lid_closed_o(st_out[IX_LID]), .battery_low_o(st_out[IX_BAT]),
      .charging_o(st_out[IX_CHG]), .charger_present_o(st_out[IX_PRS]), .test_mode_o(st_out[IX_TST]),
      .mgmt_bus_irq_o(st_out[IX_ALR]), .boot_select_o(bsel), .boot_source_o(bsrc), .config_strap_o(cfg),
      .strap_pins_input_o(spin));

   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic expect_note(input logic [2:0] k, input logic [7:0] v);
      q.push_back('{k: k, v: v});
      -> take;
   endtask

   task automatic cmp(input logic [7:0] e, input logic [7:0] a);
      checks_done++;
      if (a !== e) begin
         n_fail++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, a);
      end
   endtask

   task automatic cmp_power(input logic [7:0] e);
      cmp(e, {5'h00, mpe, cpe, stby_n});
   endtask

   task automatic cmp_reset(input logic [7:0] e);
      cmp(e, {5'h00, spin, mrst, crst_n});
   endtask

   task automatic cmp_status(input logic [7:0] e);
      cmp(e, st_out);
   endtask

   task automatic cmp_boot(input logic [7:0] e);
      cmp(e, {2'h0, bsel, bsrc});
   endtask

   task automatic cmp_strap(input logic [7:0] e);
      cmp(e, {4'h0, cfg});
   endtask

   task automatic stop_test;
      $display("checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // drains every note posted in this time step, so back-to-back notes are not lost
   always begin : watch
      note_s n;
      @(take);
      while (q.size() != 0) begin
         n = q.pop_front();
         case (n.k)
            3'h0: cmp_power(n.v);
            3'h1: cmp_reset(n.v);
            3'h2: cmp_status(n.v);
            3'h3: cmp_boot(n.v);
            default: cmp_strap(n.v);
         endcase
      end
   end

   initial begin : watchdog
      #(25 * 5000);
      n_fail++;
      stop_test();
   end

   initial begin : main
      int c;
      void'($urandom(58));
      cyc(16);
      expect_note(3'h0, 8'h00);
      expect_note(3'h1, 8'h06);
      sys_rst = 1'b0;
      cyc(6);
      expect_note(3'h0, 8'h00);
      pb_pull = 1'b0;
      cyc(4);
      expect_note(3'h0, 8'h07);
      expect_note(3'h1, 8'h01);
      susp_n = 1'b0;
      cyc(2);
      expect_note(3'h0, 8'h04);
      susp_n = 1'b1;
      cyc(2);
      expect_note(3'h0, 8'h07);
      rr_pull = 1'b1;
      cyc(4);
      expect_note(3'h1, 8'h06);
      for (c = 0; c < 8; c++) begin
         bt_gnd = ~c[2:0];
         strap = 4'($urandom);
         cyc(4);
         expect_note(3'h3, {2'h0, c[2:0], (c == 3) ? BOOT_CARRIER_SPI : BOOT_MODULE_SPI});
         expect_note(3'h4, {4'h0, strap});
      end
      rr_pull = 1'b0;
      cyc(4);
      expect_note(3'h1, 8'h01);
      bt_gnd = 3'h7;
      strap = ~strap;
      cyc(4);
      expect_note(3'h3, {2'h0, 3'h7, BOOT_MODULE_SPI});
      expect_note(3'h4, {4'h0, ~strap});
      sys_req = 1'b1;
      cyc(1);
      expect_note(3'h1, 8'h06);
      sys_req = 1'b0;
      cyc(4);
      for (c = 0; c < 8; c++) begin
         st_pull = 8'h01 << c;
         cyc(12);
         expect_note(3'h2, 8'h01 << c);
         st_pull = 8'h00;
         cyc(12);
         expect_note(3'h2, 8'h00);
      end
      // a pulse shorter than the stability count must not reach the outputs
      st_pull = 8'($urandom);
      cyc(1 + $urandom % 2);
      st_pull = 8'h00;
      cyc(12);
      expect_note(3'h2, 8'h00);
      // a longer count must swallow a pulse that the short count would pass
      deb_cyc = 16'h0008;
      st_pull = 8'hFF;
      cyc(6);
      st_pull = 8'h00;
      cyc(12);
      expect_note(3'h2, 8'h00);
      st_pull = 8'($urandom);
      cyc(12);
      expect_note(3'h2, st_pull);
      pb_pull = 1'b1;
      cyc(4);
      expect_note(3'h0, 8'h00);
      // a second reset returns boot choice, straps and statuses to their defaults
      sys_rst = 1'b1;
      cyc(2);
      expect_note(3'h3, {2'h0, BOOT_MODULE_SPI, BOOT_MODULE_SPI});
      expect_note(3'h4, {4'h0, STRAP_RST});
      expect_note(3'h2, 8'h00);
      sys_rst = 1'b0;
      cyc(2);
      expect_note(3'h1, 8'h06);
      cyc(1);
      stop_test();
   end
endmodule // module_power_boot_control_tb_top
